// file: tasr_core.sv
// Purpose: Angle, temperature and status words plus settings and command registers
// Assumes: Raw angles and temperature come from same-clock logic; straps and faults are pins
// Notes: One register per request; answer is registered one cycle after the request
`timescale 1ns/1ps
// How it works
// - Serve read-holding and write-single requests
// - X word only on dual units
// - Angle words hundredth degree, signed except the full-turn word
// - X word is raw plus offset, inverted when X inversion is on
// - Y word likewise, zero on single units
// - Range settings clamp and limit angles
// - Signed half-turn word on single units
// - Full-turn word on single units is raw plus offset
// - Full-turn word ignores X range
// - X inversion selects full-turn direction
// - Temperature signed, one degree per count
// - Status shows unit type bits
// - Y factory limit flags, dual only
// - X factory limit flags, both units
// - Y user range flags, dual only
// - X user range flags
// - Stored-data fault flags per unit type
// - Lowest status bit means any error
module tasr_core #(
    parameter int FACT_LIM_DUAL = 6000,
    parameter int FACT_LIM_SINGLE = 18000
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire tasr_pkg::tasr_req_t req,
    output tasr_pkg::tasr_resp_t resp,
    input wire logic [15:0] raw_x,
    input wire logic [15:0] raw_y,
    input wire logic [15:0] raw_half_turn,
    input wire logic [15:0] raw_full_turn,
    input wire logic [7:0] raw_temp,
    input wire logic dual_axis_strap,
    input wire logic dual_axis_store_fault,
    input wire logic single_axis_store_fault,
    output logic reboot_pulse,
    output logic reload_pulse
);
    ////////////////////////////////////////////////////////////////////////////
    // Parameter check
    if (FACT_LIM_DUAL < 1 || FACT_LIM_DUAL > 32767 || FACT_LIM_SINGLE < 1 ||
        FACT_LIM_SINGLE > 32767) begin : g_bad_lim
        $error("Factory limits must lie in 1..32767");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers
    logic [1:0] rst_sync_q; // Reset release chain
    logic rst_n; // Released reset used everywhere
    logic [2:0] pin_meta_q; // First stage, read only by second stage
    logic [2:0] pin_sync_q; // Usable pin levels
    logic cap_done_q; // Strap has been caught
    logic dual_q; // Unit type, high for dual axis

    // Reset released through two flip-flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) rst_sync_q <= 2'h0;
        else rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // Two-stage synchronisers for strap and fault pins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_q <= 3'h0;
            pin_sync_q <= 3'h0;
        end else begin
            pin_meta_q <= {dual_axis_strap, dual_axis_store_fault, single_axis_store_fault};
            pin_sync_q <= pin_meta_q;
        end
    end

    // Strap caught once, after the synchroniser has filled
    logic [1:0] cap_wait_q; // Cycles since release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_wait_q <= 2'h0;
            cap_done_q <= 1'b0;
            dual_q <= 1'b0;
        end else if (!cap_done_q) begin
            cap_wait_q <= cap_wait_q + 2'h1;
            if (cap_wait_q == 2'h2) begin
                cap_done_q <= 1'b1;
                dual_q <= pin_sync_q[2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Request decode
    logic [15:0] x_off_q, x_inv_q, x_rng_q, y_off_q, y_inv_q, y_rng_q; // Settings
    logic [15:0] reload_q, reboot_q; // Command registers
    wire is_rd = req.valid && req.func == tasr_pkg::FUNC_READ_HOLDING;
    wire is_wr = req.valid && req.func == tasr_pkg::FUNC_WRITE_SINGLE;
    wire y_ok = dual_q; // Y settings exist on dual units only
    wire a_xo = req.addr == tasr_pkg::ADDR_X_OFFSET;
    wire a_xi = req.addr == tasr_pkg::ADDR_X_INVERT;
    wire a_xr = req.addr == tasr_pkg::ADDR_X_RANGE;
    wire a_yo = req.addr == tasr_pkg::ADDR_Y_OFFSET && y_ok;
    wire a_yi = req.addr == tasr_pkg::ADDR_Y_INVERT && y_ok;
    wire a_yr = req.addr == tasr_pkg::ADDR_Y_RANGE && y_ok;
    wire a_rl = req.addr == tasr_pkg::ADDR_RELOAD;
    wire a_rb = req.addr == tasr_pkg::ADDR_REBOOT;
    wire a_wr = a_xo || a_xi || a_xr || a_yo || a_yi || a_yr || a_rl || a_rb;
    wire bad_inv = (a_xi || a_yi) && req.wdata != tasr_pkg::INVERT_OFF &&
        req.wdata != tasr_pkg::INVERT_ON;
    wire wr_ok = is_wr && a_wr && !bad_inv; // Accepted write
    wire do_reload = wr_ok && a_rl && req.wdata != 16'h0000;
    wire do_reboot = wr_ok && a_rb && req.wdata != 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // Settings registers; a reload restores factory settings
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            x_off_q <= tasr_pkg::RST_OFFSET;
            x_inv_q <= tasr_pkg::RST_INVERT;
            x_rng_q <= tasr_pkg::RST_X_RANGE;
            y_off_q <= tasr_pkg::RST_OFFSET;
            y_inv_q <= tasr_pkg::RST_INVERT;
            y_rng_q <= tasr_pkg::RST_Y_RANGE_DUAL;
        end else if (do_reload) begin
            x_off_q <= tasr_pkg::RST_OFFSET;
            x_inv_q <= tasr_pkg::RST_INVERT;
            x_rng_q <= tasr_pkg::RST_X_RANGE;
            y_off_q <= tasr_pkg::RST_OFFSET;
            y_inv_q <= tasr_pkg::RST_INVERT;
            y_rng_q <= dual_q ? tasr_pkg::RST_Y_RANGE_DUAL : tasr_pkg::RST_Y_RANGE_SINGLE;
        end else if (wr_ok) begin
            if (a_xo) x_off_q <= req.wdata;
            if (a_xi) x_inv_q <= req.wdata;
            if (a_xr) x_rng_q <= req.wdata;
            if (a_yo) y_off_q <= req.wdata;
            if (a_yi) y_inv_q <= req.wdata;
            if (a_yr) y_rng_q <= req.wdata;
        end
    end

    // Commands read back their value for one cycle, then clear themselves
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reload_q <= tasr_pkg::RST_COMMAND;
            reboot_q <= tasr_pkg::RST_COMMAND;
            reload_pulse <= 1'b0;
            reboot_pulse <= 1'b0;
        end else begin
            reload_q <= (wr_ok && a_rl) ? req.wdata : tasr_pkg::RST_COMMAND;
            reboot_q <= (wr_ok && a_rb) ? req.wdata : tasr_pkg::RST_COMMAND;
            reload_pulse <= do_reload;
            reboot_pulse <= do_reboot;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Angle arithmetic
    // Clamp to a symmetric limit, then saturate to a signed word
    function automatic logic [15:0] clamp16(input logic signed [24:0] v,
                                            input logic signed [24:0] l);
        logic signed [24:0] m;
        m = (l > tasr_pkg::WORD_MAX) ? tasr_pkg::WORD_MAX : l;
        if (v > m) clamp16 = m[15:0];
        else if (v < -m) clamp16 = 16'((-m));
        else clamp16 = v[15:0];
    endfunction

    // Half-turn path feeds the X settings on single units
    wire [15:0] ax_raw = dual_q ? raw_x : raw_half_turn;
    wire signed [17:0] x_sum = $signed({{2{ax_raw[15]}}, ax_raw}) +
        $signed({{2{x_off_q[15]}}, x_off_q});
    wire signed [17:0] x_val = (x_inv_q == tasr_pkg::INVERT_ON) ? -x_sum : x_sum;
    wire signed [17:0] y_sum = $signed({{2{raw_y[15]}}, raw_y}) +
        $signed({{2{y_off_q[15]}}, y_off_q});
    wire signed [17:0] y_val = (y_inv_q == tasr_pkg::INVERT_ON) ? -y_sum : y_sum;
    // User limits in hundredths of a degree; a negative range counts as zero
    wire [24:0] x_lim_u = x_rng_q[15] ? 25'h0 : {9'h0, x_rng_q} * tasr_pkg::COUNTS_PER_DEG;
    wire [24:0] y_lim_u = y_rng_q[15] ? 25'h0 : {9'h0, y_rng_q} * tasr_pkg::COUNTS_PER_DEG;
    wire signed [24:0] x_lim = $signed(x_lim_u);
    wire signed [24:0] y_lim = $signed(y_lim_u);
    wire signed [24:0] x_ext = 25'(x_val);
    wire signed [24:0] y_ext = 25'(y_val);
    wire [15:0] x_clamped = clamp16(x_ext, x_lim);
    wire [15:0] y_clamped = clamp16(y_ext, y_lim);
    // Factory limits on the raw measurement
    wire signed [17:0] fx_lim = dual_q ? 18'(FACT_LIM_DUAL) : 18'(FACT_LIM_SINGLE);
    wire signed [17:0] fy_lim = 18'(FACT_LIM_DUAL);
    wire signed [17:0] ax_ext = $signed({{2{ax_raw[15]}}, ax_raw});
    wire signed [17:0] ay_ext = $signed({{2{raw_y[15]}}, raw_y});

    // Full-turn word: raw plus offset wrapped into one turn, no range applied
    wire signed [17:0] f_sum = $signed({2'h0, raw_full_turn}) +
        $signed({{2{x_off_q[15]}}, x_off_q});
    wire signed [17:0] f_wrap = (f_sum < 0) ? f_sum + tasr_pkg::FULL_TURN :
        (f_sum >= tasr_pkg::FULL_TURN) ? f_sum - tasr_pkg::FULL_TURN : f_sum;
    wire signed [17:0] f_dir = (x_inv_q == tasr_pkg::INVERT_ON && f_wrap != 0) ?
        tasr_pkg::FULL_TURN - f_wrap : f_wrap;

    ////////////////////////////////////////////////////////////////////////////
    // Status word assembly
    logic [15:0] st_d; // Next status word
    always_comb begin
        st_d = 16'h0000;
        st_d[tasr_pkg::ST_DUAL_MODE] = dual_q;
        st_d[tasr_pkg::ST_SINGLE_MODE] = !dual_q;
        st_d[tasr_pkg::ST_Y_FACT_HIGH] = dual_q && ay_ext > fy_lim;
        st_d[tasr_pkg::ST_Y_FACT_LOW] = dual_q && ay_ext < -fy_lim;
        st_d[tasr_pkg::ST_X_FACT_HIGH] = ax_ext > fx_lim;
        st_d[tasr_pkg::ST_X_FACT_LOW] = ax_ext < -fx_lim;
        st_d[tasr_pkg::ST_Y_USER_HIGH] = dual_q && y_ext > y_lim;
        st_d[tasr_pkg::ST_Y_USER_LOW] = dual_q && y_ext < -y_lim;
        st_d[tasr_pkg::ST_X_USER_HIGH] = x_ext > x_lim;
        st_d[tasr_pkg::ST_X_USER_LOW] = x_ext < -x_lim;
        st_d[tasr_pkg::ST_DUAL_STORE_FAULT] = dual_q && pin_sync_q[1];
        st_d[tasr_pkg::ST_SINGLE_STORE_FAULT] = !dual_q && pin_sync_q[0];
        st_d[tasr_pkg::ST_ERROR_PRESENT] = |st_d[12:4] || st_d[2];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Measurement word registers
    logic [15:0] x_word_q, y_word_q, s180_q, s360_q, temp_q, status_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            x_word_q <= 16'h0000;
            y_word_q <= 16'h0000;
            s180_q <= 16'h0000;
            s360_q <= 16'h0000;
            temp_q <= 16'h0000;
            status_q <= 16'h0000;
        end else begin
            x_word_q <= dual_q ? x_clamped : 16'h0000;
            y_word_q <= dual_q ? y_clamped : 16'h0000;
            s180_q <= dual_q ? 16'h0000 : x_clamped;
            s360_q <= dual_q ? 16'h0000 : f_dir[15:0];
            temp_q <= {{8{raw_temp[7]}}, raw_temp};
            status_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read selection and answer
    wire [15:0] rd_data =
        (req.addr == tasr_pkg::ADDR_X_ANGLE) ? x_word_q :
        (req.addr == tasr_pkg::ADDR_Y_ANGLE) ? y_word_q :
        (req.addr == tasr_pkg::ADDR_S180_ANGLE) ? s180_q :
        (req.addr == tasr_pkg::ADDR_S360_ANGLE) ? s360_q :
        (req.addr == tasr_pkg::ADDR_TEMP) ? temp_q :
        (req.addr == tasr_pkg::ADDR_STATUS) ? status_q :
        a_xo ? x_off_q : a_xi ? x_inv_q : a_xr ? x_rng_q :
        a_yo ? y_off_q : a_yi ? y_inv_q : a_yr ? y_rng_q :
        a_rl ? reload_q : reboot_q;
    wire rd_hit = a_wr || (req.addr >= tasr_pkg::ADDR_X_ANGLE &&
        req.addr <= tasr_pkg::ADDR_STATUS);
    wire [7:0] exc_d = (!is_rd && !is_wr) ? tasr_pkg::EXC_ILLEGAL_FUNC :
        (is_rd && !rd_hit) || (is_wr && !a_wr) ? tasr_pkg::EXC_ILLEGAL_ADDR :
        (is_wr && bad_inv) ? tasr_pkg::EXC_ILLEGAL_VALUE : tasr_pkg::EXC_NONE;

    // Answer one cycle after every request; accepted writes echo the written value
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            resp <= '0;
        end else begin
            resp.valid <= req.valid;
            resp.exc <= req.valid ? exc_d : tasr_pkg::EXC_NONE;
            resp.data <= !req.valid || exc_d != tasr_pkg::EXC_NONE ? 16'h0000 :
                is_wr ? req.wdata : rd_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_answer_one_cycle: assert property (req.valid |=> resp.valid)
        else $error("Request not answered next cycle");
    chk_bad_func_refused: assert property (req.valid && !is_rd && !is_wr |=>
        resp.exc == tasr_pkg::EXC_ILLEGAL_FUNC)
        else $error("Unsupported function not refused");
    chk_x_zero_single: assert property (!$past(dual_q) |-> x_word_q == 16'h0000)
        else $error("X word nonzero on single unit");
    chk_y_zero_single: assert property (!$past(dual_q) |-> y_word_q == 16'h0000)
        else $error("Y word nonzero on single unit");
    chk_half_zero_dual: assert property ($past(dual_q) |-> s180_q == 16'h0000 &&
        s360_q == 16'h0000)
        else $error("Single-axis words nonzero on dual unit");
    chk_full_turn_bound: assert property (s360_q < 16'h8CA0)
        else $error("Full-turn word beyond one turn");
    chk_status_unused_zero: assert property (status_q[15:13] == 3'h0)
        else $error("Unused status bits set");
    chk_error_summary: assert property (status_q[0] == (|status_q[12:4] || status_q[2]))
        else $error("Error summary bit wrong");
    // First cycle after release still shows the cleared status word, so skip it
    chk_unit_type_bits: assert property ($past(rst_n) |-> status_q[3] == $past(dual_q) &&
        status_q[1] == !$past(dual_q))
        else $error("Unit type bits wrong");
    // Back-to-back nonzero reboot writes give back-to-back pulses, one per write
    chk_reboot_pulse: assert property ($past(rst_n) |-> reboot_pulse == $past(do_reboot))
        else $error("Reboot pulse not one cycle");
    chk_temp_sign_ext: assert property ($past(rst_n) |-> temp_q == {{8{$past(raw_temp[7])}},
        $past(raw_temp)})
        else $error("Temperature word not sign extended");
    cov_read_ok: cover property (is_rd ##1 resp.exc == tasr_pkg::EXC_NONE);
    cov_write_ok: cover property (wr_ok ##1 resp.valid);
    cov_reload: cover property (do_reload ##1 reload_pulse);
    cov_user_high: cover property (status_q[tasr_pkg::ST_X_USER_HIGH]);
endmodule

// file: tasr_pkg.sv
// Purpose: Shared constants and carriers for the tilt angle and status register block
// Assumes: One request port that carries already-deframed read and write register requests
// Notes: Addresses are register addresses on the serial network, one 16-bit word each
package tasr_pkg;
    // Register addresses
    localparam logic [15:0] ADDR_X_ANGLE = 16'h0001;
    localparam logic [15:0] ADDR_Y_ANGLE = 16'h0002;
    localparam logic [15:0] ADDR_S180_ANGLE = 16'h0003;
    localparam logic [15:0] ADDR_S360_ANGLE = 16'h0004;
    localparam logic [15:0] ADDR_TEMP = 16'h0005;
    localparam logic [15:0] ADDR_STATUS = 16'h0006;
    localparam logic [15:0] ADDR_X_OFFSET = 16'h0016;
    localparam logic [15:0] ADDR_X_INVERT = 16'h0017;
    localparam logic [15:0] ADDR_X_RANGE = 16'h0018;
    localparam logic [15:0] ADDR_Y_OFFSET = 16'h0020;
    localparam logic [15:0] ADDR_Y_INVERT = 16'h0021;
    localparam logic [15:0] ADDR_Y_RANGE = 16'h0022;
    localparam logic [15:0] ADDR_RELOAD = 16'h0033;
    localparam logic [15:0] ADDR_REBOOT = 16'h0034;
    // Reset and factory values of the settings
    localparam logic [15:0] RST_OFFSET = 16'h0000;
    localparam logic [15:0] RST_INVERT = 16'h0001;
    localparam logic [15:0] RST_X_RANGE = 16'h001E;
    localparam logic [15:0] RST_Y_RANGE_DUAL = 16'h001E;
    localparam logic [15:0] RST_Y_RANGE_SINGLE = 16'h00B4;
    localparam logic [15:0] RST_COMMAND = 16'h0000;
    // Sign inversion encodings
    localparam logic [15:0] INVERT_OFF = 16'h0001;
    localparam logic [15:0] INVERT_ON = 16'h0002;
    // Function codes and exception codes
    localparam logic [7:0] FUNC_READ_HOLDING = 8'h03;
    localparam logic [7:0] FUNC_WRITE_SINGLE = 8'h06;
    localparam logic [7:0] EXC_NONE = 8'h00;
    localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
    localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
    localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
    // Status word bit positions
    localparam int ST_ERROR_PRESENT = 0;
    localparam int ST_SINGLE_MODE = 1;
    localparam int ST_SINGLE_STORE_FAULT = 2;
    localparam int ST_DUAL_MODE = 3;
    localparam int ST_DUAL_STORE_FAULT = 4;
    localparam int ST_X_USER_LOW = 5;
    localparam int ST_X_USER_HIGH = 6;
    localparam int ST_Y_USER_LOW = 7;
    localparam int ST_Y_USER_HIGH = 8;
    localparam int ST_X_FACT_LOW = 9;
    localparam int ST_X_FACT_HIGH = 10;
    localparam int ST_Y_FACT_LOW = 11;
    localparam int ST_Y_FACT_HIGH = 12;
    // Angle scaling
    localparam logic [24:0] COUNTS_PER_DEG = 25'h0000064;
    localparam logic signed [17:0] FULL_TURN = 18'sh08CA0;
    localparam logic signed [24:0] WORD_MAX = 25'sh0007FFF;
    // Request and answer carriers
    typedef struct packed {
        logic valid;
        logic [7:0] func;
        logic [15:0] addr;
        logic [15:0] wdata;
    } tasr_req_t;
    typedef struct packed {
        logic valid;
        logic [7:0] exc;
        logic [15:0] data;
    } tasr_resp_t;
endpackage

// file: tasr_master.sv
// Purpose: Behavioural network master that issues register requests to the tilt block
// Assumes: Requests arrive deframed, one 16-bit register per request
// Notes: Idle request fields show the inverse of the last value so stale data never matches
`timescale 1ns/1ps
module tasr_master (
    input wire logic clk,
    output tasr_pkg::tasr_req_t req,
    input wire tasr_pkg::tasr_resp_t resp
);
    ////////////////////////////////////////////////////////////////////////////////
    // Idle bus at time zero
    initial begin
        req = '0;
    end
    // One transfer: request stands one cycle, answer is awaited for a bounded time
    task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] w,
                        output logic got, output logic [7:0] e, output logic [15:0] d);
        int n;
        @(negedge clk);
        req = '{valid: 1'b1, func: f, addr: a, wdata: w};
        @(negedge clk);
        req = '{valid: 1'b0, func: ~f, addr: ~a, wdata: ~w};
        n = 0;
        // Answer may already stand; otherwise wait a few cycles at most
        while (resp.valid !== 1'b1 && n < 3) begin
            @(negedge clk);
            n++;
        end
        got = resp.valid;
        e = resp.exc;
        d = resp.data;
    endtask
endmodule

// file: test_tilt_angle_status_registers.sv
// Purpose: Self-checking bench for the tilt angle and status register block
// Assumes: Inputs change on the falling edge; the strap is held through each reset
// Notes: Runs a dual-axis phase and a single-axis phase with seeded random angles
`timescale 1ns/1ps
module test_tilt_angle_status_registers;
    localparam int FL_D = 6000;
    localparam int FL_S = 18000;
    logic clk, rst_b, dual_axis_strap, dual_axis_store_fault, single_axis_store_fault;
    logic reboot_pulse, reload_pulse, dual;
    logic [15:0] raw_x, raw_y, raw_half_turn, raw_full_turn, xinv, yinv;
    logic [7:0] raw_temp;
    logic signed [15:0] xoff, yoff;
    tasr_pkg::tasr_req_t req;
    tasr_pkg::tasr_resp_t resp;
    int xrng, yrng, num_errors, tests_run;
    integer seed = 1;
    tasr_core #(.FACT_LIM_DUAL(FL_D), .FACT_LIM_SINGLE(FL_S)) tasr_core_inst (.clk(clk),
        .rst_b(rst_b), .req(req), .resp(resp), .raw_x(raw_x), .raw_y(raw_y),
        .raw_half_turn(raw_half_turn), .raw_full_turn(raw_full_turn), .raw_temp(raw_temp),
        .dual_axis_strap(dual_axis_strap), .dual_axis_store_fault(dual_axis_store_fault),
        .single_axis_store_fault(single_axis_store_fault), .reboot_pulse(reboot_pulse),
        .reload_pulse(reload_pulse));
    tasr_master tasr_master_inst (.clk(clk), .req(req), .resp(resp));
    ////////////////////////////////////////////////////////////////////////////////
    // Expected words from the raw inputs and the bench copy of the settings
    function automatic int lim(int v, int l);
        return (v > l) ? l : ((v < -l) ? -l : v);
    endfunction
    function automatic logic [15:0] exp_word(logic [15:0] a);
        int xv, yv, fv, rx, ry, fl;
        logic [15:0] st;
        rx = $signed(dual ? raw_x : raw_half_turn);
        ry = $signed(raw_y);
        fl = dual ? FL_D : FL_S;
        xv = (rx + xoff) * ((xinv == tasr_pkg::INVERT_ON) ? -1 : 1);
        yv = (ry + yoff) * ((yinv == tasr_pkg::INVERT_ON) ? -1 : 1);
        fv = (int'(raw_full_turn) + xoff) % 36000;
        fv = (fv < 0) ? fv + 36000 : fv;
        fv = (xinv == tasr_pkg::INVERT_ON && fv != 0) ? 36000 - fv : fv;
        st = '0;
        st[3] = dual;
        st[1] = !dual;
        st[4] = dual & dual_axis_store_fault;
        st[2] = !dual & single_axis_store_fault;
        st[10] = rx > fl;
        st[9] = rx < -fl;
        st[6] = xv > xrng * 100;
        st[5] = xv < -xrng * 100;
        st[12] = dual & (ry > FL_D);
        st[11] = dual & (ry < -FL_D);
        st[8] = dual & (yv > yrng * 100);
        st[7] = dual & (yv < -yrng * 100);
        st[0] = (|st[12:4]) | st[2];
        case (a)
            tasr_pkg::ADDR_X_ANGLE: return dual ? 16'(lim(xv, xrng * 100)) : 16'h0000;
            tasr_pkg::ADDR_Y_ANGLE: return dual ? 16'(lim(yv, yrng * 100)) : 16'h0000;
            tasr_pkg::ADDR_S180_ANGLE: return dual ? 16'h0000 : 16'(lim(xv, xrng * 100));
            tasr_pkg::ADDR_S360_ANGLE: return dual ? 16'h0000 : 16'(fv);
            tasr_pkg::ADDR_TEMP: return {{8{raw_temp[7]}}, raw_temp};
            default: return st;
        endcase
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    // Compare tasks, one per kind of result
    task automatic cmp_word(input logic [24:0] got, input logic [24:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp, input string m);
        cmp_word({24'h0, got}, {24'h0, exp}, m);
    endtask
    // One access with its expected exception and data
    task automatic acc(input logic [7:0] f, input logic [15:0] a, input logic [15:0] w,
                       input logic [7:0] e, input logic [15:0] d);
        logic g;
        logic [7:0] ge;
        logic [15:0] gd;
        tasr_master_inst.xfer(f, a, w, g, ge, gd);
        cmp_word({g, ge, gd}, {1'b1, e, d}, $sformatf("access %h", a));
    endtask
    // Accepted write, mirrored in the bench settings
    task automatic wr(input logic [15:0] a, input logic [15:0] w);
        acc(tasr_pkg::FUNC_WRITE_SINGLE, a, w, tasr_pkg::EXC_NONE, w);
        case (a)
            tasr_pkg::ADDR_X_OFFSET: xoff = w;
            tasr_pkg::ADDR_X_INVERT: xinv = w;
            tasr_pkg::ADDR_X_RANGE: xrng = int'(w);
            tasr_pkg::ADDR_Y_OFFSET: yoff = w;
            tasr_pkg::ADDR_Y_INVERT: yinv = w;
            tasr_pkg::ADDR_Y_RANGE: yrng = int'(w);
            default: ;
        endcase
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] d);
        acc(tasr_pkg::FUNC_READ_HOLDING, a, 16'h0000, tasr_pkg::EXC_NONE, d);
    endtask
    // Read back the settings the unit type allows
    task automatic check_settings();
        rd(tasr_pkg::ADDR_X_OFFSET, xoff);
        rd(tasr_pkg::ADDR_X_INVERT, xinv);
        rd(tasr_pkg::ADDR_X_RANGE, 16'(xrng));
        if (dual) begin
            rd(tasr_pkg::ADDR_Y_OFFSET, yoff);
            rd(tasr_pkg::ADDR_Y_INVERT, yinv);
            rd(tasr_pkg::ADDR_Y_RANGE, 16'(yrng));
        end
        rd(tasr_pkg::ADDR_REBOOT, 16'h0000);
        rd(tasr_pkg::ADDR_RELOAD, 16'h0000);
    endtask
    // Reset with the strap already at the unit type
    task automatic do_reset(input logic d);
        @(negedge clk);
        rst_b = 1'b0;
        dual_axis_strap = d;
        dual = d;
        {xoff, yoff, xinv, yinv, xrng, yrng} = {32'h0, 32'h00010001, 32'd30, 32'd30};
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        repeat (8) @(negedge clk);
    endtask
    // Random angles, faults and settings, then every measurement word
    task automatic rand_round();
        @(negedge clk);
        raw_x = 16'($random(seed) % 7001);
        raw_y = 16'($random(seed) % 7001);
        raw_half_turn = 16'($random(seed) % 20001);
        raw_full_turn = 16'({$random(seed)} % 36000);
        raw_temp = 8'($random(seed));
        dual_axis_store_fault = ({$random(seed)} % 4) == 0;
        single_axis_store_fault = ({$random(seed)} % 4) == 0;
        wr(tasr_pkg::ADDR_X_OFFSET, 16'($random(seed) % 3001));
        wr(tasr_pkg::ADDR_X_INVERT, 16'(1 + {$random(seed)} % 2));
        wr(tasr_pkg::ADDR_X_RANGE, 16'({$random(seed)} % 71));
        if (dual) begin
            wr(tasr_pkg::ADDR_Y_OFFSET, 16'($random(seed) % 3001));
            wr(tasr_pkg::ADDR_Y_INVERT, 16'(1 + {$random(seed)} % 2));
            wr(tasr_pkg::ADDR_Y_RANGE, 16'({$random(seed)} % 71));
        end
        repeat (5) @(negedge clk);
        for (int a = 1; a <= 6; a++) begin
            rd(16'(a), exp_word(16'(a)));
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Clock at 100 MHz
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Watchdog far beyond the expected run length
    initial begin
        #200000;
        num_errors++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        end_of_test();
    end
    // Main sequence
    initial begin
        {rst_b, raw_x, raw_y, raw_half_turn, raw_full_turn, raw_temp} = '0;
        {dual_axis_strap, dual_axis_store_fault, single_axis_store_fault, dual} = '0;
        {num_errors, tests_run} = '0;
        for (int ph = 1; ph >= 0; ph--) begin
            do_reset(ph[0]);
            check_settings();
            for (int i = 0; i < 20; i++) rand_round();
            $display("test random words done, dual %0d", ph);
            acc(8'h04, tasr_pkg::ADDR_STATUS, 16'h0, tasr_pkg::EXC_ILLEGAL_FUNC, 16'h0);
            acc(8'h03, 16'h0007, 16'h0, tasr_pkg::EXC_ILLEGAL_ADDR, 16'h0);
            acc(8'h06, tasr_pkg::ADDR_X_ANGLE, 16'h5, tasr_pkg::EXC_ILLEGAL_ADDR, 16'h0);
            acc(8'h06, tasr_pkg::ADDR_X_INVERT, 16'h3, tasr_pkg::EXC_ILLEGAL_VALUE, 16'h0);
            if (!dual) acc(8'h03, tasr_pkg::ADDR_Y_RANGE, 16'h0, tasr_pkg::EXC_ILLEGAL_ADDR, 16'h0);
            wr(tasr_pkg::ADDR_REBOOT, 16'h0000);
            cmp_bit(reboot_pulse, 1'b0, "reboot on zero");
            wr(tasr_pkg::ADDR_REBOOT, 16'h8000);
            cmp_bit(reboot_pulse, 1'b1, "reboot pulse");
            cmp_bit(reload_pulse, 1'b0, "reload quiet");
            wr(tasr_pkg::ADDR_RELOAD, 16'h0001);
            cmp_bit(reload_pulse, 1'b1, "reload pulse");
            {xoff, yoff, xinv, yinv, xrng, yrng} = {32'h0, 32'h00010001, 32'd30, 32'd30};
            check_settings();
            $display("test refusals and commands done, dual %0d", ph);
        end
        end_of_test();
    end
endmodule
